// ### logic/fpe_pkg.sv
// Constants and carrier types for the flash protection and overlay block.
// Assumes an 8-bit register port and eight flash blocks.
package fpe_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [1:0] OFS_CTRL1 = 2'h0;
    localparam logic [1:0] OFS_CTRL2 = 2'h1;
    localparam logic [1:0] OFS_EBMASK = 2'h2;
    localparam logic [1:0] OFS_OVL = 2'h3;

    // ==========================================================
    // Field positions and reset values
    localparam int FAULT_POS = 7;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] EBMASK_RST = 8'h00;
    localparam logic [7:0] OVL_RST = 8'h00;
    localparam logic [7:0] EBMASK_NONE = 8'h00;
    // Overlay select 0..3 lands on blocks base..base+3
    localparam logic [2:0] OVL_BLK_BASE = 3'h3;
    localparam int SYNC_STAGES = 2;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic pad;
        logic soft_write_allow;
        logic clr_setup_bit;
        logic write_setup_bit;
        logic clr_verify;
        logic write_verify;
        logic clr_blk_arm;
        logic cell_write_arm;
    } fpe_ctrl1_t;

    typedef struct packed {
        logic [4:0] pad;
        logic overlay_on;
        logic overlay_sel_hi;
        logic overlay_sel_lo;
    } fpe_ovl_t;

    typedef struct packed {
        logic in_flash;
        logic ovl_hit;
        logic ram_orig;
        logic [2:0] blk;
    } fpe_map_t;

    typedef struct packed {
        logic to_flash;
        logic to_ram;
        logic blocked;
    } fpe_route_t;

endpackage : fpe_pkg

// ### logic/fpe_addr_map.sv
// Address decoder: flash block index, overlay hit and RAM window hit.
// Assumes flash starts at address zero in equal power-of-two blocks.
`timescale 1ns/1ps

module fpe_addr_map import fpe_pkg::*; #(
    parameter int AW = 20,
    parameter int BLK_AW = 14,
    parameter int NBLK = 8,
    parameter int RAM_OVL_BLK = 40
) (
    input wire logic [AW-1:0] addr_i,
    input wire fpe_ovl_t ovl_i,
    output fpe_map_t map_o
);

    logic [2:0] blk;
    logic [2:0] sel_blk;
    logic upper_zero;

    // ==========================================================
    // Decode
    assign blk = addr_i[BLK_AW+2:BLK_AW];
    assign upper_zero = (addr_i[AW-1:BLK_AW+3] == '0);
    assign sel_blk = OVL_BLK_BASE
        + {1'b0, ovl_i.overlay_sel_hi, ovl_i.overlay_sel_lo};

    always_comb begin
        map_o.blk = blk;
        map_o.in_flash = upper_zero && (32'(blk) < NBLK);
        // RAM stands in for the selected block while the overlay is on
        map_o.ovl_hit = map_o.in_flash && ovl_i.overlay_on
            && (blk == sel_blk);
        map_o.ram_orig = ovl_i.overlay_on && (addr_i[AW-1:BLK_AW]
            == (AW-BLK_AW)'(RAM_OVL_BLK));
    end

endmodule : fpe_addr_map

// ### logic/fpe_flash_protect.sv
// Flash protection, error protection and RAM overlay control.
// Assumes CPU event strobes on the same clock; the write-allow pin is
// asynchronous and is synchronised here.
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps

// How it works
// - Pin low clears control and mask registers, blocks writes
// - Reset or standby clears control and mask registers, protects
// - Error state keeps control and mask registers
// - Soft write allow zero protects everything
// - Mask gates erase per block only
// - Mask zero protects every block from erase
// - Overlay on protects all blocks
// - Protection stops arm bits entering modes
// - Illegal event sets fault, enters error state
// - Error state aborts, no restart
// - Verify modes still allowed in error
// - Flash read during operation sets fault
// - Exception during operation sets fault
// - Sleep during operation sets fault
// - Bus grant during operation sets fault
// - Fault clears only on reset, hardware standby
// - Overlay maps RAM over selected block
// - Overlaid block and RAM window inaccessible
// - Select one-zero-one overlays block four
// - Overlay off restores flash mapping
// - Erase never touches overlaid area
// - Mode follows setup and mode bits
// - No program or erase with pin low
module fpe_flash_protect import fpe_pkg::*; #(
    parameter int NBLK = 8,
    parameter int AW = 20,
    parameter int BLK_AW = 14,
    parameter int RAM_OVL_BLK = 40
) (
    input wire logic MCLK_I,
    input wire logic ARST_N_I,
    input wire logic WRITE_ALLOW_PIN_I,
    input wire logic SW_STANDBY_I,
    input wire logic HW_STANDBY_I,
    input wire logic SLEEP_I,
    input wire logic EXC_TAKEN_I,
    input wire logic BUS_GRANT_I,
    input wire logic CPU_RD_I,
    input wire logic [AW-1:0] CPU_ADDR_I,
    input wire logic [1:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    output logic PROG_O,
    output logic ERASE_O,
    output logic PV_MODE_O,
    output logic EV_MODE_O,
    output logic [NBLK-1:0] ERASE_BLK_O,
    output fpe_route_t ROUTE_O
);

    // ==========================================================
    // Elaboration checks
    generate
        if (NBLK < 7 || NBLK > 8 || AW <= BLK_AW + 3) begin : g_bad
            $error("fpe_flash_protect: unsupported NBLK or AW");
        end
    endgenerate

    // ==========================================================
    // Declarations
    logic [SYNC_STAGES-1:0] wa_sync_q;
    logic wa_s;
    fpe_ctrl1_t ctrl1_q;
    logic [7:0] ebm_q;
    fpe_ovl_t ovl_q;
    logic fault_q;
    logic [7:0] rdata_q;
    logic prog_q;
    logic erase_q;
    logic pv_q;
    logic ev_q;
    logic [NBLK-1:0] eblk_q;
    fpe_route_t route_q;
    fpe_map_t cpu_map;
    fpe_route_t route_d;
    logic hw_clear;
    logic sw_prot;
    logic armed;
    logic flash_rd;
    logic fault_evt;
    logic prog_d;
    logic erase_d;
    logic [NBLK-1:0] ovl_blk_mask;
    logic wr_ctrl1;
    logic wr_ebm;
    logic wr_ovl;

    // ==========================================================
    // Write-allow pin synchroniser
    // Only the second stage is read, to keep metastability contained
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            wa_sync_q <= '0;
        end else begin
            wa_sync_q <= {wa_sync_q[0], WRITE_ALLOW_PIN_I};
        end
    end
    assign wa_s = wa_sync_q[SYNC_STAGES-1];

    // ==========================================================
    // Address map for CPU accesses
    fpe_addr_map #(
        .AW(AW),
        .BLK_AW(BLK_AW),
        .NBLK(NBLK),
        .RAM_OVL_BLK(RAM_OVL_BLK)
    ) u_map (
        .addr_i(CPU_ADDR_I),
        .ovl_i(ovl_q),
        .map_o(cpu_map)
    );

    // ==========================================================
    // Protection terms
    // Hardware protection: pin low or any standby
    assign hw_clear = !wa_s || SW_STANDBY_I
        || HW_STANDBY_I;
    assign sw_prot = !ctrl1_q.soft_write_allow
        || ovl_q.overlay_on;
    assign armed = ctrl1_q.cell_write_arm
        || ctrl1_q.clr_blk_arm;
    // A redirected access reads RAM, so it is no flash read
    assign flash_rd = CPU_RD_I && cpu_map.in_flash
        && !cpu_map.ovl_hit;
    assign fault_evt = armed && (flash_rd || EXC_TAKEN_I
        || SLEEP_I || BUS_GRANT_I);

    assign wr_ctrl1 = WR_I && (ADDR_I == OFS_CTRL1);
    assign wr_ebm = WR_I && (ADDR_I == OFS_EBMASK);
    assign wr_ovl = WR_I && (ADDR_I == OFS_OVL);

    // ==========================================================
    // Control register and erase mask
    // The error state never clears them, so software can inspect them
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ctrl1_q <= fpe_ctrl1_t'(CTRL1_RST);
        end else if (hw_clear) begin
            ctrl1_q <= fpe_ctrl1_t'(CTRL1_RST);
        end else if (wr_ctrl1) begin
            ctrl1_q <= fpe_ctrl1_t'({1'b0, WDATA_I[6:0]});
        end
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ebm_q <= EBMASK_RST;
        end else if (hw_clear) begin
            ebm_q <= EBMASK_RST;
        end else if (wr_ebm) begin
            ebm_q <= WDATA_I;
        end
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ovl_q <= fpe_ovl_t'(OVL_RST);
        end else if (wr_ovl) begin
            ovl_q <= fpe_ovl_t'({5'h00, WDATA_I[2:0]});
        end
    end

    // ==========================================================
    // Fault flag: set beats clear; software writes cannot clear it
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            fault_q <= 1'b0;
        end else if (fault_evt) begin
            fault_q <= 1'b1;
        end else if (HW_STANDBY_I) begin
            fault_q <= 1'b0;
        end
    end

    // ==========================================================
    // Operating mode
    assign prog_d = wa_s && !hw_clear && !sw_prot && !fault_q
        && ctrl1_q.write_setup_bit
        && ctrl1_q.cell_write_arm;
    assign erase_d = wa_s && !hw_clear && !sw_prot && !fault_q
        && (ebm_q != EBMASK_NONE) && ctrl1_q.clr_setup_bit
        && ctrl1_q.clr_blk_arm;

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            prog_q <= 1'b0;
            erase_q <= 1'b0;
        end else begin
            prog_q <= prog_d;
            erase_q <= erase_d;
        end
    end

    // Verify stays reachable in the error state
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            pv_q <= 1'b0;
            ev_q <= 1'b0;
        end else begin
            pv_q <= !hw_clear && ctrl1_q.soft_write_allow
                && ctrl1_q.write_verify;
            ev_q <= !hw_clear && ctrl1_q.soft_write_allow
                && ctrl1_q.clr_verify;
        end
    end

    // ==========================================================
    // Per-block erase enables
    generate
        for (genvar b = 0; b < NBLK; b++) begin : g_blk
            assign ovl_blk_mask[b] = ovl_q.overlay_on
                && (OVL_BLK_BASE + {1'b0, ovl_q.overlay_sel_hi,
                ovl_q.overlay_sel_lo} == 3'(b));
        end
    endgenerate

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            eblk_q <= '0;
        end else if (erase_d) begin
            eblk_q <= ebm_q[NBLK-1:0] & ~ovl_blk_mask;
        end else begin
            eblk_q <= '0;
        end
    end

    // ==========================================================
    // Access routing
    always_comb begin
        route_d.blocked = cpu_map.ram_orig;
        route_d.to_ram = cpu_map.ovl_hit;
        route_d.to_flash = cpu_map.in_flash
            && !cpu_map.ovl_hit;
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            route_q <= '0;
        end else begin
            route_q <= route_d;
        end
    end

    // ==========================================================
    // Register read port, data one cycle after the strobe
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rdata_q <= 8'h00;
        end else if (RD_I) begin
            unique case (ADDR_I)
                OFS_CTRL1: rdata_q <= ctrl1_q;
                OFS_CTRL2: rdata_q <= 8'(fault_q) << FAULT_POS;
                OFS_EBMASK: rdata_q <= ebm_q;
                OFS_OVL: rdata_q <= ovl_q;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign RDATA_O = rdata_q;
    assign PROG_O = prog_q;
    assign ERASE_O = erase_q;
    assign PV_MODE_O = pv_q;
    assign EV_MODE_O = ev_q;
    assign ERASE_BLK_O = eblk_q;
    assign ROUTE_O = route_q;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!ARST_N_I);

    pin_low_clear_a: assert property (
        !wa_s |=> ctrl1_q == CTRL1_RST && ebm_q == EBMASK_RST
            && !PROG_O && !ERASE_O)
        else $error("pin low did not clear control state");

    standby_clear_a: assert property (
        SW_STANDBY_I || HW_STANDBY_I |=> ctrl1_q == CTRL1_RST
            ##1 !PROG_O && !ERASE_O)
        else $error("standby did not clear control state");

    err_keeps_regs_a: assert property (
        fault_q && !hw_clear && !WR_I |=> $stable(ctrl1_q)
            && $stable(ebm_q))
        else $error("error state changed control registers");

    soft_off_prot_a: assert property (
        !ctrl1_q.soft_write_allow |=> !PROG_O && !ERASE_O)
        else $error("mode entered with soft write allow clear");

    mask_zero_prot_a: assert property (
        ebm_q == EBMASK_NONE |=> !ERASE_O && ERASE_BLK_O == '0)
        else $error("erase ran with empty block mask");

    ovl_prot_a: assert property (
        ovl_q.overlay_on |=> !PROG_O && !ERASE_O)
        else $error("mode entered while overlay on");

    fault_set_a: assert property (
        fault_evt |=> fault_q [*2])
        else $error("illegal event did not set fault");

    fault_sticky_a: assert property (
        fault_q && !HW_STANDBY_I |=> fault_q)
        else $error("fault flag cleared without standby");

    err_abort_a: assert property (
        $rose(fault_q) |-> ##1 (!PROG_O && !ERASE_O) [*3])
        else $error("operation continued after fault");

    no_fault_idle_a: assert property (
        !armed && !fault_q |=> !fault_q)
        else $error("fault set while not armed");

    err_verify_a: assert property (
        fault_q && !hw_clear && ctrl1_q.soft_write_allow
            && ctrl1_q.write_verify |=> PV_MODE_O)
        else $error("verify refused in error state");

    ovl_route_a: assert property (
        ovl_q == fpe_ovl_t'(8'h05) && cpu_map.in_flash
            && cpu_map.blk == 3'h4 |=> ROUTE_O.to_ram
            && !ROUTE_O.to_flash)
        else $error("block four not overlaid");

    prog_cov_c: cover property (!PROG_O ##1 PROG_O);
    erase_cov_c: cover property (ERASE_O && ERASE_BLK_O != '0);
    fault_cov_c: cover property ($rose(fault_q) ##1 PV_MODE_O);
    ovl_cov_c: cover property (ROUTE_O.to_ram ##1 ROUTE_O.blocked);

endmodule : fpe_flash_protect

// ### verif/fpe_cpu_model.sv
// CPU and write-allow pin model for the flash protection block.
// Assumes one clock; every signal moves by NBA after a rising edge.
`timescale 1ns/1ps

module fpe_cpu_model import fpe_pkg::*; (
    input wire logic clk_i,
    output logic pin_o,
    output logic [1:0] stby_o,
    output logic [3:0] ev_o,
    output logic [19:0] cpu_addr_o,
    output logic [1:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    // ==========================================================
    // Idle state; no NMI line exists, so none is ever raised
    initial begin
        pin_o = 1'b1;
        stby_o = 2'h0;
        ev_o = 4'h0;
        cpu_addr_o = 20'h00000;
        addr_o = 2'h0;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // ==========================================================
    // Register port cycles; data inverted after use, never left stale
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_o <= 1'b1;
        addr_o <= a;
        wdata_o <= d;
        @(posedge clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
    endtask : wr

    task automatic rd(input logic [1:0] a);
        @(posedge clk_i);
        rd_o <= 1'b1;
        addr_o <= a;
        @(posedge clk_i);
        rd_o <= 1'b0;
    endtask : rd

    // One-cycle event strobe: {grant, exception, sleep, flash read}
    task automatic pulse(input logic [3:0] e);
        @(posedge clk_i);
        ev_o <= e;
        @(posedge clk_i);
        ev_o <= 4'h0;
    endtask : pulse
endmodule : fpe_cpu_model

// ### verif/fpe_flash_protect_bench.sv
// Self-checking bench for the flash protection and overlay block.
// Assumes fpe_cpu_model drives every design input except clock and reset.
`timescale 1ns/1ps

module fpe_flash_protect_bench import fpe_pkg::*; ();
    logic clk;
    logic arst_n;
    logic rd_d = 1'b0;
    logic [7:0] rdata;
    logic prog, erase, pv, ev;
    logic [7:0] eblk;
    logic [7:0] c;
    fpe_route_t route;
    logic pin, wr, rd;
    logic [1:0] stby, addr;
    logic [3:0] evs;
    logic [19:0] caddr;
    logic [7:0] wdata;
    logic [7:0] exp_q [$];
    int error_cnt = 0;
    int num_checks = 0;
    int seed = 52;
    // {ovl, mask, ctrl1, modes prog/erase/pv/ev, erase blocks}
    logic [39:0] tbl [9] = '{40'h00_00_D1_08_00, 40'h00_00_11_00_00,
        40'h00_00_62_00_00, 40'h00_81_62_04_81, 40'h00_81_51_08_00,
        40'h05_FF_51_00_00, 40'h05_FF_62_00_00, 40'h00_00_44_02_00,
        40'h00_00_48_01_00};
    // {ovl, address block, route}
    logic [23:0] rt [6] = '{24'h05_04_02, 24'h05_28_01, 24'h05_02_04,
        24'h00_04_04, 24'h06_05_02, 24'h06_04_04};

    fpe_cpu_model m (.clk_i(clk), .pin_o(pin), .stby_o(stby),
        .ev_o(evs), .cpu_addr_o(caddr), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd));

    fpe_flash_protect dut (.MCLK_I(clk), .ARST_N_I(arst_n),
        .WRITE_ALLOW_PIN_I(pin), .SW_STANDBY_I(stby[0]),
        .HW_STANDBY_I(stby[1]), .SLEEP_I(evs[1]), .EXC_TAKEN_I(evs[2]),
        .BUS_GRANT_I(evs[3]), .CPU_RD_I(evs[0]), .CPU_ADDR_I(caddr),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .PROG_O(prog), .ERASE_O(erase), .PV_MODE_O(pv),
        .EV_MODE_O(ev), .ERASE_BLK_O(eblk), .ROUTE_O(route));

    // ==========================================================
    // Helpers
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] e);
        num_checks++;
        if (got !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic rdx(input logic [1:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        m.rd(a);
    endtask : rdx

    task automatic mchk(input logic [7:0] e);
        chk({4'h0, prog, erase, pv, ev}, e);
    endtask : mchk

    task automatic setm(input logic [7:0] o, b, d);
        m.wr(OFS_OVL, o);
        m.wr(OFS_EBMASK, b);
        m.wr(OFS_CTRL1, d);
        cyc(2);
    endtask : setm

    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    // ==========================================================
    // Read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        rd_d <= rd;
        if (rd_d === 1'b1 && exp_q.size() > 0) begin
            chk(rdata, exp_q.pop_front());
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        finish_test();
    end

    // ==========================================================
    // Scenarios
    initial begin
        arst_n = 1'b0;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        cyc(5);
        rdx(OFS_CTRL1, CTRL1_RST);
        rdx(OFS_CTRL2, 8'h00);
        rdx(OFS_EBMASK, EBMASK_RST);
        rdx(OFS_OVL, OVL_RST);
        for (int i = 0; i < 9; i++) begin
            setm(tbl[i][39:32], tbl[i][31:24], tbl[i][23:16]);
            mchk(tbl[i][15:8]);
            chk(eblk, tbl[i][7:0]);
            rdx(OFS_CTRL1, tbl[i][23:16] & 8'h7F);
        end
        for (int j = 0; j < 2; j++) begin
            setm(8'h00, 8'h81, 8'h51);
            m.pin_o <= (j != 0);
            m.stby_o <= {1'b0, j == 1};
            cyc(4);
            mchk(8'h00);
            m.wr(OFS_CTRL1, 8'h51);
            rdx(OFS_CTRL1, 8'h00);
            rdx(OFS_EBMASK, 8'h00);
            m.pin_o <= 1'b1;
            m.stby_o <= 2'h0;
            cyc(4);
        end
        // Overlay select picks the block; the RAM window goes dark
        for (int i = 0; i < 6; i++) begin
            m.wr(OFS_OVL, rt[i][23:16]);
            m.cpu_addr_o <= {rt[i][13:8], 14'($random(seed))};
            cyc(2);
            chk({5'h0, route}, rt[i][7:0]);
        end
        m.cpu_addr_o <= 20'h00100;
        setm(8'h00, 8'h00, 8'h44);
        for (int k = 0; k < 4; k++) begin
            m.pulse(4'h1 << k);
        end
        rdx(OFS_CTRL2, 8'h00);
        for (int k = 0; k < 4; k++) begin
            c = k[0] ? 8'h51 : 8'h62;
            setm(8'h00, 8'h81, c);
            mchk(k[0] ? 8'h08 : 8'h04);
            m.pulse(4'h1 << k);
            cyc(3);
            mchk(8'h00);
            rdx(OFS_CTRL2, 8'h80);
            rdx(OFS_CTRL1, c);
            rdx(OFS_EBMASK, 8'h81);
            m.wr(OFS_CTRL1, 8'h00);
            m.wr(OFS_CTRL1, c);
            m.wr(OFS_CTRL2, 8'h00);
            cyc(2);
            mchk(8'h00);
            rdx(OFS_CTRL2, 8'h80);
            // Odd passes try erase verify, even ones program verify
            m.wr(OFS_CTRL1, k[0] ? 8'h48 : 8'h44);
            cyc(2);
            mchk(k[0] ? 8'h01 : 8'h02);
            m.stby_o <= 2'h2;
            cyc(2);
            m.stby_o <= 2'h0;
            cyc(2);
            rdx(OFS_CTRL2, 8'h00);
            rdx(OFS_CTRL1, 8'h00);
        end
        // Second reset in mid-run
        m.wr(OFS_OVL, 8'h05);
        arst_n <= 1'b0;
        cyc(2);
        arst_n <= 1'b1;
        cyc(2);
        rdx(OFS_OVL, OVL_RST);
        cyc(3);
        finish_test();
    end
endmodule : fpe_flash_protect_bench
